// ### src/ebp_pkg.sv
package ebp_pkg;

    localparam logic [7:0] OFS_UNIT_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_SHUTDOWN_CONTROL = 8'h04;
    localparam logic [7:0] OFS_TIMER_SOURCE     = 8'h08;
    localparam logic [7:0] OFS_TIMER_PERIOD     = 8'h0c;
    localparam logic [7:0] OFS_STEERING         = 8'h10;
    localparam logic [7:0] OFS_DEADBAND         = 8'h14;
    localparam logic [7:0] OFS_TIMER_CONTROL    = 8'h18;
    localparam logic [7:0] OFS_TIMER_COUNT      = 8'h1c;
    localparam logic [7:0] OFS_DUTY_HIGH        = 8'h20;
    localparam logic [7:0] OFS_DUTY_SHADOW      = 8'h24;

    localparam logic [7:0] RST_UNIT_CONTROL  = 8'h00;
    localparam logic [7:0] RST_SHUTDOWN      = 8'h00;
    localparam logic [7:0] RST_TIMER_SOURCE  = 8'h00;
    localparam logic [7:0] RST_TIMER_PERIOD  = 8'hff;
    localparam logic [7:0] RST_STEERING      = 8'h01;
    localparam logic [7:0] RST_DEADBAND      = 8'h00;
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_DUTY_HIGH     = 8'h00;

    localparam logic [7:0] MASK_STEERING      = 8'h1f;
    localparam logic [7:0] MASK_TIMER_CONTROL = 8'h7f;

    // Unit control fields
    localparam int BRIDGE_MODE_LSB = 6;
    localparam int DUTY_LOW_LSB    = 4;
    localparam int ENH_MODE_LSB    = 2;
    localparam int POL_AC_BIT      = 1;
    localparam int POL_BD_BIT      = 0;
    localparam logic [1:0] ENH_PWM_CODE = 2'h3;

    // Other fields
    localparam int STEER_SYNC_BIT  = 4;
    localparam int TIMER_RUN_BIT   = 2;
    localparam int PRESCALE_LSB    = 0;

    localparam logic [1:0] BM_SINGLE = 2'h0;
    localparam logic [1:0] BM_HALF   = 2'h2;
    localparam logic [1:0] BM_FWD    = 2'h1;
    localparam logic [1:0] BM_REV    = 2'h3;

    // Dead-band step is one instruction cycle of four clocks
    localparam int DB_STEP_SHIFT = 2;
    // Direction change lead, in timer counts, less one
    localparam logic [8:0] DIR_LEAD = 9'h003;

    // Prescaler terminal counts for 1:1, 1:4 and 1:16 timer steps
    localparam logic [5:0] PRE_LIM_1  = 6'h03;
    localparam logic [5:0] PRE_LIM_4  = 6'h0f;
    localparam logic [5:0] PRE_LIM_16 = 6'h3f;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } ebp_state_e;

endpackage : ebp_pkg

// ### src/ebp_timebase.sv
`timescale 1ns/100ps
`default_nettype none
module ebp_timebase
    import ebp_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       run_in,
    input  wire logic [1:0] prescale_in,
    input  wire logic [7:0] period_in,
    input  wire logic       cnt_wr_in,
    input  wire logic [7:0] cnt_wdata_in,
    output logic      [7:0] count_out,
    output logic      [9:0] tbase_out,
    output logic            period_start_out,
    output logic            near_end_out
);

    logic [5:0] pre_q;
    logic [7:0] tmr_q;
    logic       inc;
    logic [1:0] low_bits;

    function automatic logic [5:0] pre_limit(input logic [1:0] ps);
        case (ps)
            2'h0:    pre_limit = PRE_LIM_1;
            2'h1:    pre_limit = PRE_LIM_4;
            default: pre_limit = PRE_LIM_16;
        endcase
    endfunction : pre_limit

    assign inc = run_in && (pre_q == pre_limit(prescale_in));

    // A count write restarts the prescaler so the new value gets a full step
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pre_q <= 6'h00;
        else if (cnt_wr_in || inc)
            pre_q <= 6'h00;
        else if (run_in)
            pre_q <= pre_q + 6'h01;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            tmr_q <= 8'h00;
        else if (cnt_wr_in)
            tmr_q <= cnt_wdata_in;
        else if (inc)
            tmr_q <= (tmr_q == period_in) ? 8'h00 : tmr_q + 8'h01;
    end

    always_comb
    begin
        case (prescale_in)
            2'h0:    low_bits = pre_q[1:0];
            2'h1:    low_bits = pre_q[3:2];
            default: low_bits = pre_q[5:4];
        endcase
    end

    assign count_out        = tmr_q;
    assign tbase_out        = {tmr_q, low_bits};
    assign period_start_out = inc && (tmr_q == period_in);
    assign near_end_out     = ({1'b0, tmr_q} + DIR_LEAD) >= {1'b0, period_in};

endmodule : ebp_timebase
`default_nettype wire

// ### src/ebp_bridge_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module ebp_bridge_pwm
    import ebp_pkg::*;
#(
    parameter int DUTY_W = 10,
    parameter int DB_W   = 7
)
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             out_a_out,
    output logic             out_a_own_out,
    output logic             out_b_out,
    output logic             out_b_own_out,
    output logic             out_c_out,
    output logic             out_c_own_out,
    output logic             out_d_out,
    output logic             out_d_own_out
);

    if (DUTY_W != 10 || DB_W != 7)
        $error("Duty must be ten bits and dead-band seven bits");

    logic [7:0]       unit_control_q;
    logic [7:0]       shutdown_control_q;
    logic [7:0]       timer_source_q;
    logic [7:0]       timer_period_q;
    logic [7:0]       steering_q;
    logic [7:0]       deadband_q;
    logic [7:0]       timer_control_q;
    logic [7:0]       duty_high_q;
    logic [DUTY_W-1:0] duty_shadow_q;
    logic [31:0]      prdata_q;
    logic [31:0]      rd_d;
    logic             wr_en;
    logic             cnt_wr;
    logic [7:0]       tmr_count;
    logic [DUTY_W-1:0] tbase;
    logic             period_start;
    logic             near_end;
    ebp_state_e       st_q;
    logic             enh;
    logic             pwm_q;
    logic             pwm;
    logic [DUTY_W-1:0] duty_next;
    logic [1:0]       bmode_req;
    logic             full_req;
    logic             dir_q;
    logic             blank_q;
    logic [1:0]       bmode;
    logic [3:0]       steer_q;
    logic [1:0]       db_raw;
    logic [1:0]       db_raw_prev_q;
    logic [8:0]       db_cnt_q [2];
    logic [1:0]       db_out;
    logic [8:0]       db_dly;
    logic [3:0]       act;
    logic [3:0]       used;
    logic [3:0]       inv;
    logic [3:0]       lvl_q;
    logic [3:0]       own_q;

    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            OFS_UNIT_CONTROL, OFS_SHUTDOWN_CONTROL, OFS_TIMER_SOURCE,
            OFS_TIMER_PERIOD, OFS_STEERING, OFS_DEADBAND, OFS_TIMER_CONTROL,
            OFS_TIMER_COUNT, OFS_DUTY_HIGH, OFS_DUTY_SHADOW:
                addr_hit = 1'b1;
            default:
                addr_hit = 1'b0;
        endcase
    endfunction : addr_hit

    // Zero-wait slave; read data is captured in the setup phase
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_hit(paddr_in);
    assign prdata_out  = prdata_q;
    assign wr_en       = psel_in && penable_in && pwrite_in && pstrb_in[0]
                         && addr_hit(paddr_in);
    assign cnt_wr      = wr_en && (paddr_in == OFS_TIMER_COUNT);

    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (paddr_in)
            OFS_UNIT_CONTROL:     rd_d[7:0] = unit_control_q;
            OFS_SHUTDOWN_CONTROL: rd_d[7:0] = shutdown_control_q;
            OFS_TIMER_SOURCE:     rd_d[7:0] = timer_source_q;
            OFS_TIMER_PERIOD:     rd_d[7:0] = timer_period_q;
            OFS_STEERING:         rd_d[7:0] = steering_q;
            OFS_DEADBAND:         rd_d[7:0] = deadband_q;
            OFS_TIMER_CONTROL:    rd_d[7:0] = timer_control_q;
            OFS_TIMER_COUNT:      rd_d[7:0] = tmr_count;
            OFS_DUTY_HIGH:        rd_d[7:0] = duty_high_q;
            OFS_DUTY_SHADOW:      rd_d[7:0] = duty_shadow_q[DUTY_W-1:2];
            default:              rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            prdata_q <= 32'h0000_0000;
        else if (psel_in && !penable_in && !pwrite_in)
            prdata_q <= rd_d;
    end

    // Shutdown bits are only stored; their pin action is not modelled here
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            unit_control_q     <= RST_UNIT_CONTROL;
            shutdown_control_q <= RST_SHUTDOWN;
            timer_source_q     <= RST_TIMER_SOURCE;
            timer_period_q     <= RST_TIMER_PERIOD;
            steering_q         <= RST_STEERING;
            deadband_q         <= RST_DEADBAND;
            timer_control_q    <= RST_TIMER_CONTROL;
            duty_high_q        <= RST_DUTY_HIGH;
        end
        else if (wr_en)
        begin
            case (paddr_in)
                OFS_UNIT_CONTROL:     unit_control_q     <= pwdata_in[7:0];
                OFS_SHUTDOWN_CONTROL: shutdown_control_q <= pwdata_in[7:0];
                OFS_TIMER_SOURCE:     timer_source_q     <= pwdata_in[7:0];
                OFS_TIMER_PERIOD:     timer_period_q     <= pwdata_in[7:0];
                OFS_STEERING:         steering_q <= pwdata_in[7:0] & MASK_STEERING;
                OFS_DEADBAND:         deadband_q         <= pwdata_in[7:0];
                OFS_TIMER_CONTROL:    timer_control_q <= pwdata_in[7:0] & MASK_TIMER_CONTROL;
                OFS_DUTY_HIGH:        duty_high_q        <= pwdata_in[7:0];
                default:              ;
            endcase
        end
    end

    ebp_timebase u_timebase
    (
        .sys_clk_in       (sys_clk_in),
        .rst_n_in         (rst_n_in),
        .run_in           (timer_control_q[TIMER_RUN_BIT]),
        .prescale_in      (timer_control_q[PRESCALE_LSB +: 2]),
        .period_in        (timer_period_q),
        .cnt_wr_in        (cnt_wr),
        .cnt_wdata_in     (pwdata_in[7:0]),
        .count_out        (tmr_count),
        .tbase_out        (tbase),
        .period_start_out (period_start),
        .near_end_out     (near_end)
    );

    assign enh       = unit_control_q[ENH_MODE_LSB +: 2] == ENH_PWM_CODE;
    assign duty_next = {duty_high_q, unit_control_q[DUTY_LOW_LSB +: 2]};
    assign bmode_req = unit_control_q[BRIDGE_MODE_LSB +: 2];
    assign full_req  = bmode_req[0];

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st_q <= ST_IDLE;
        else
        begin
            unique case (st_q)
                ST_IDLE: if (enh) st_q <= ST_WAIT;
                ST_WAIT: if (!enh) st_q <= ST_IDLE;
                         else if (period_start) st_q <= ST_RUN;
                ST_RUN:  if (!enh) st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            duty_shadow_q <= '0;
        else if (period_start)
            duty_shadow_q <= duty_next;
    end

    // A duty above the period never matches, so the output simply stays on
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pwm_q <= 1'b0;
        else if (!enh)
            pwm_q <= 1'b0;
        else if (period_start)
            pwm_q <= duty_next != '0;
        else if (tbase == duty_shadow_q)
            pwm_q <= 1'b0;
    end

    // The match cycle is already inactive, so the width is exactly duty steps
    assign pwm = pwm_q && (tbase != duty_shadow_q);

    // Direction and blanking for the full bridge
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            dir_q <= 1'b0;
        else if (!full_req || st_q != ST_RUN)
            dir_q <= bmode_req[1];
        else if (dir_q != bmode_req[1] && near_end)
            dir_q <= bmode_req[1];
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            blank_q <= 1'b0;
        else if (period_start || !full_req)
            blank_q <= 1'b0;
        else if (st_q == ST_RUN && dir_q != bmode_req[1] && near_end)
            blank_q <= 1'b1;
    end

    assign bmode = full_req ? {dir_q, 1'b1} : bmode_req;

    // Steering taken at once, or at period start when synchronised
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            steer_q <= RST_STEERING[3:0];
        else if (!steering_q[STEER_SYNC_BIT] || period_start)
            steer_q <= steering_q[3:0];
    end

    // Dead-band: each rising edge waits count times four clocks
    assign db_raw = (st_q == ST_RUN) ? {!pwm, pwm} : 2'b00;
    assign db_dly = {deadband_q[DB_W-1:0], 2'b00};

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            db_raw_prev_q <= 2'b00;
        else
            db_raw_prev_q <= db_raw;
    end

    for (genvar i = 0; i < 2; i++)
    begin : g_db
        logic rise;
        assign rise = db_raw[i] && !db_raw_prev_q[i];
        always_ff @(posedge sys_clk_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
                db_cnt_q[i] <= 9'h000;
            else if (rise && db_dly != 9'h000)
                db_cnt_q[i] <= db_dly - 9'h001;
            else if (db_cnt_q[i] != 9'h000)
                db_cnt_q[i] <= db_cnt_q[i] - 9'h001;
        end
        // A fall before the count ends leaves the output off all period
        assign db_out[i] = db_raw[i] && !(rise && db_dly != 9'h000)
                           && db_cnt_q[i] == 9'h000;
    end

    // Bit order is D, C, B, A
    always_comb
    begin
        act  = 4'h0;
        used = 4'h0;
        if (st_q == ST_RUN)
        begin
            unique case (bmode)
                BM_SINGLE: act = {4{pwm}} & steer_q;
                BM_HALF:   act = {2'b00, db_out};
                BM_FWD:    act = {pwm && !blank_q, 2'b00, 1'b1};
                BM_REV:    act = {2'b01, pwm && !blank_q, 1'b0};
            endcase
        end
        if (enh)
        begin
            unique case (bmode)
                BM_SINGLE: used = steer_q;
                BM_HALF:   used = 4'h3;
                BM_FWD:    used = 4'hf;
                BM_REV:    used = 4'hf;
            endcase
        end
    end

    assign inv = {unit_control_q[POL_BD_BIT], unit_control_q[POL_AC_BIT],
                  unit_control_q[POL_BD_BIT], unit_control_q[POL_AC_BIT]};

    // Port direction stays with software; the pin only shows this when enabled
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lvl_q <= 4'h0;
            own_q <= 4'h0;
        end
        else
        begin
            lvl_q <= act ^ inv;
            own_q <= used;
        end
    end

    assign out_a_out     = lvl_q[0];
    assign out_b_out     = lvl_q[1];
    assign out_c_out     = lvl_q[2];
    assign out_d_out     = lvl_q[3];
    assign out_a_own_out = own_q[0];
    assign out_b_own_out = own_q[1];
    assign out_c_own_out = own_q[2];
    assign out_d_own_out = own_q[3];

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    release_zero_a: assert property (unit_control_q == 8'h00 |=> own_q == 4'h0)
        else $error("Pins still owned after control cleared");
    hold_off_a: assert property (st_q != ST_RUN |=> (lvl_q ^ $past(inv)) == 4'h0)
        else $error("Waveform before first period start");
    half_cd_unused_a: assert property (enh && bmode == BM_HALF |=> own_q[3:2] == 2'b00)
        else $error("Half-bridge owns C or D");
    half_compl_a: assert property (st_q == ST_RUN && bmode == BM_HALF && deadband_q[6:0] == 7'h00
                                   |=> (lvl_q[0] ^ $past(inv[0])) != (lvl_q[1] ^ $past(inv[1])))
        else $error("Half-bridge B not complement of A");
    fwd_levels_a: assert property (st_q == ST_RUN && bmode == BM_FWD
                                   |=> (lvl_q[2:0] ^ $past(inv[2:0])) == 3'b001)
        else $error("Forward static outputs wrong");
    rev_levels_a: assert property (st_q == ST_RUN && bmode == BM_REV
                                   |=> (lvl_q[3] ^ $past(inv[3])) == 1'b0
                                       && (lvl_q[2] ^ $past(inv[2])) == 1'b1
                                       && (lvl_q[0] ^ $past(inv[0])) == 1'b0)
        else $error("Reverse static outputs wrong");
    shadow_latch_a: assert property (period_start |=> duty_shadow_q == $past(duty_next))
        else $error("Duty not latched at period start");
    match_clear_a: assert property (enh && !period_start && tbase == duty_shadow_q |=> !pwm_q)
        else $error("Output not cleared on duty match");
    dead_hold_a: assert property ($rose(db_raw[0]) && deadband_q[6:0] != 7'h00
                                  |-> !db_out[0] ##1 !db_out[0])
        else $error("Dead-band did not delay rising edge");
    blank_mod_a: assert property (blank_q && st_q == ST_RUN && full_req |-> act[3] == 1'b0
                                  && act[1] == 1'b0)
        else $error("Modulated output active while blanked");
    steer_own_a: assert property (enh && bmode == BM_SINGLE |=> own_q == $past(steer_q))
        else $error("Single mode owns unsteered pin");

    half_run_c: cover property (st_q == ST_RUN && bmode == BM_HALF && db_out[1]);
    fwd_run_c:  cover property (st_q == ST_RUN && bmode == BM_FWD && pwm_q);
    rev_run_c:  cover property (st_q == ST_RUN && bmode == BM_REV && pwm_q);
    dir_chg_c:  cover property ($rose(blank_q) ##[1:600] period_start);

endmodule : ebp_bridge_pwm
`default_nettype wire

// ### testbench/ebp_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module ebp_switch_model
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [3:0] out_in,
    input  wire logic [3:0] own_in,
    output logic      [3:0] pin_out,
    output logic            shoot_out
);
    // Unowned pins fall to the gate pull-down, so a stale level never shows
    assign pin_out = own_in & out_in;
    // Sticky: both switches of one leg on together would short the supply
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            shoot_out <= 1'b0;
        else if ((pin_out[0] & pin_out[1]) | (pin_out[2] & pin_out[3]))
            shoot_out <= 1'b1;
    end
endmodule : ebp_switch_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ebp_pkg::*;
    typedef struct {
        logic [7:0] ctl, db, tc;
        int         win, ea, eb, ec, ed;
        logic [3:0] own;
    } ebp_case_s;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, shoot;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0]  pstrb, outs, owns, pins;
    logic        e;
    int          n_mismatch, cmp_count, c[4];
    logic [15:0] rtab[8] = '{{OFS_UNIT_CONTROL, RST_UNIT_CONTROL},
        {OFS_SHUTDOWN_CONTROL, RST_SHUTDOWN}, {OFS_TIMER_SOURCE, RST_TIMER_SOURCE},
        {OFS_TIMER_PERIOD, RST_TIMER_PERIOD}, {OFS_STEERING, RST_STEERING},
        {OFS_DEADBAND, RST_DEADBAND}, {OFS_TIMER_CONTROL, RST_TIMER_CONTROL},
        {OFS_DUTY_HIGH, RST_DUTY_HIGH}};
    // Period 3 gives 16 clocks at 1:1 and 64 at 1:4; duty 6 sits in the two low bits as well
    ebp_case_s cases[8] = '{
        '{8'h2c, 8'h00, 8'h04, 16, 6, 0, 0, 0, 4'h1},
        '{8'h2f, 8'h00, 8'h04, 16, 10, 0, 0, 0, 4'h1},
        '{8'hac, 8'h00, 8'h04, 16, 6, 10, 0, 0, 4'h3},
        '{8'hac, 8'h01, 8'h04, 16, 2, 6, 0, 0, 4'h3},
        '{8'hac, 8'h02, 8'h04, 16, 0, 2, 0, 0, 4'h3},
        '{8'h6c, 8'h00, 8'h04, 16, 16, 0, 0, 6, 4'hf},
        '{8'hec, 8'h00, 8'h04, 16, 0, 6, 16, 0, 4'hf},
        '{8'h2c, 8'h00, 8'h05, 64, 24, 0, 0, 0, 4'h1}};
    ebp_bridge_pwm dut (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .out_a_out(outs[0]), .out_a_own_out(owns[0]), .out_b_out(outs[1]),
        .out_b_own_out(owns[1]), .out_c_out(outs[2]), .out_c_own_out(owns[2]),
        .out_d_out(outs[3]), .out_d_own_out(owns[3]));
    ebp_switch_model sw (.sys_clk_in(clk), .rst_n_in(rst_n), .out_in(outs),
        .own_in(owns), .pin_out(pins), .shoot_out(shoot));
    always #4 clk = ~clk;
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= wr ? 4'hf : 4'h0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Counts high samples per pin, taken on the falling edge where levels settle
    task automatic count_pins(input int n);
        c = '{0, 0, 0, 0};
        repeat (n)
        begin
            @(negedge clk);
            for (int k = 0; k < 4; k++)
                c[k] += (pins[k] === 1'b1);
        end
        @(posedge clk);
    endtask : count_pins
    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rtab[i])
        begin
            apb(1'b0, rtab[i][15:8], 32'h0);
            check("reset value", {24'h0, rtab[i][7:0]}, d);
        end
        check("own after reset", 32'h0, {28'h0, owns});
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped error", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, d);
        $display("test registers done");
        apb(1'b1, OFS_TIMER_PERIOD, 32'h03);
        apb(1'b1, OFS_DUTY_HIGH, 32'h01);
        foreach (cases[i])
        begin
            apb(1'b1, OFS_TIMER_CONTROL, {24'h0, cases[i].tc});
            apb(1'b1, OFS_UNIT_CONTROL, {24'h0, cases[i].ctl});
            apb(1'b1, OFS_DEADBAND, {24'h0, cases[i].db});
            repeat (2 * cases[i].win) @(posedge clk);
            check("own", {28'h0, cases[i].own}, {28'h0, owns});
            count_pins(cases[i].win);
            check("a high", cases[i].ea, c[0]);
            check("b high", cases[i].eb, c[1]);
            check("c high", cases[i].ec, c[2]);
            check("d high", cases[i].ed, c[3]);
            $display("test mode %0d done", i);
        end
        apb(1'b1, OFS_STEERING, 32'h0a);
        repeat (128) @(posedge clk);
        check("steered own", 32'h0a, {28'h0, owns});
        count_pins(64);
        check("steer a", 32'd0, c[0]);
        check("steer b", 32'd24, c[1]);
        check("steer c", 32'd0, c[2]);
        check("steer d", 32'd24, c[3]);
        $display("test steering done");
        apb(1'b1, OFS_TIMER_COUNT, 32'h02);
        apb(1'b0, OFS_TIMER_COUNT, 32'h0);
        check("timer count", 32'h02, d);
        $display("test timer count done");
        apb(1'b0, OFS_DUTY_SHADOW, 32'h0);
        check("duty shadow", 32'h01, d);
        apb(1'b1, OFS_DUTY_SHADOW, 32'hff);
        apb(1'b0, OFS_DUTY_SHADOW, 32'h0);
        check("shadow read only", 32'h01, d);
        check("leg short", 32'h0, {31'h0, shoot});
        apb(1'b1, OFS_UNIT_CONTROL, 32'h0);
        repeat (2) @(posedge clk);
        check("own released", 32'h0, {28'h0, owns});
        $display("test release done");
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
